/* pkg/hop_pkg.sv */
// shared constants and types for the auto frequency step sequencer
package hop_pkg;
  localparam int FREQ_W = 32;
  localparam int LEVEL_W = 16;
  localparam int IDX_W = 7;
  localparam int MAX_POINTS = 100;
  localparam int DWELL_W = 24;
  // role encoding on the role port
  localparam logic [1:0] ROLE_LEADER = 2'h0;
  localparam logic [1:0] ROLE_TIMED = 2'h1;
  localparam logic [1:0] ROLE_LEVEL = 2'h3;
  // fraction of the dwell before a level-follower measurement: 2/3
  localparam int MEAS_NUM = 2;
  localparam int MEAS_DEN = 3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ARM = 3'h1,
    ST_DWELL = 3'h3,
    ST_WAITLO = 3'h2,
    ST_STEP = 3'h6
  } seq_state_t;
endpackage

/* pkg/hop_if.sv */
// dwell timer link between sequencer and timer
`timescale 1ns/1ps
interface hop_if;
  logic restart;
  logic [hop_pkg::DWELL_W-1:0] dwell_cycles;
  logic two_thirds;
  logic full;
  modport seq (output restart, output dwell_cycles,
               input two_thirds, input full);
  modport tmr (input restart, input dwell_cycles,
               output two_thirds, output full);
endinterface

/* design/dwell_timer.sv */
// dwell timer giving a two-thirds mark and a full-period mark
`timescale 1ns/1ps
module dwell_timer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // link to sequencer
  hop_if.tmr t
);
  import hop_pkg::*;
  logic [hop_pkg::DWELL_W-1:0] cnt_r;
  logic [hop_pkg::DWELL_W+1:0] cnt3;
  logic [hop_pkg::DWELL_W+1:0] lim2;
  // compare 3*elapsed against 2*dwell, avoiding a divider
  assign cnt3 = {2'h0, cnt_r} * 26'(MEAS_DEN);
  assign lim2 = {2'h0, t.dwell_cycles} * 26'(MEAS_NUM);
  assign t.two_thirds = cnt3 >= lim2;
  assign t.full = cnt_r >= t.dwell_cycles;
  // elapsed counter, saturates at the full period
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cnt_r <= '0;
    else if (t.restart) cnt_r <= '0;
    else if (!t.full) cnt_r <= cnt_r + 1'b1;
  end
endmodule // dwell_timer

/* design/hop_sequencer.sv */
// auto frequency step sequencer for a selective level receiver
// What this block does
// - at most 100 points, equal to point count (one if zero)
// - linear increments or fixed-frequency list in order
// - leader offers one-pass and repeat-pass
// - timed follower arms at low limit above threshold
// - below arm threshold, step on dwell timer
// - after high limit, return low and re-arm
// - both ends share limits, dwell, increment, points
// - level follower measures at two thirds dwell
// - level follower advances below threshold after dwell
// - start/stop starts, second press ends early
// - high limit: stop if one-pass, else restart
`timescale 1ns/1ps
module hop_sequencer #(
  parameter int DWELL_DEF = 1000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // configuration
  input wire logic [1:0] role,
  input wire logic auto_hop_mode,
  input wire logic repeat_pass,
  input wire logic [hop_pkg::FREQ_W-1:0] sweep_low_freq,
  input wire logic [hop_pkg::FREQ_W-1:0] sweep_high_freq,
  input wire logic [hop_pkg::FREQ_W-1:0] freq_increment,
  input wire logic [hop_pkg::IDX_W-1:0] list_first_entry,
  input wire logic [hop_pkg::IDX_W-1:0] list_last_entry,
  input wire logic [hop_pkg::IDX_W-1:0] point_count,
  input wire logic [hop_pkg::DWELL_W-1:0] dwell_cycles,
  input wire logic [hop_pkg::LEVEL_W-1:0] arm_level_limit,
  input wire logic [hop_pkg::LEVEL_W-1:0] advance_level_limit,
  // command and level input
  input wire logic start_stop,
  input wire logic [hop_pkg::LEVEL_W-1:0] level,
  // fixed-frequency list lookup
  output logic [hop_pkg::IDX_W-1:0] list_addr,
  input wire logic [hop_pkg::FREQ_W-1:0] list_freq,
  // status and results
  output logic [hop_pkg::FREQ_W-1:0] tuned_freq,
  output logic step_strobe,
  output logic measure_strobe,
  output logic [hop_pkg::IDX_W-1:0] point_idx,
  output logic running
);
  import hop_pkg::*;
  seq_state_t state_r, state_nxt;
  hop_if tif();
  logic [FREQ_W-1:0] lin_freq_r;
  logic [IDX_W-1:0] addr_r, pidx_r, last_pts;
  logic step_r, meas_r, measured_r;
  logic lvl_above_arm, lvl_above_adv, at_end, do_step, do_wrap;
  logic leader, timed, lvlf, meas_now;

  dwell_timer dwell_timer_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .t(tif.tmr)
  );

  // role decode and level comparisons
  // code 2 is unused and would park in the arm state until stopped
  assign leader = role == ROLE_LEADER;
  assign timed = role == ROLE_TIMED;
  assign lvlf = role == ROLE_LEVEL;
  assign lvl_above_arm = level > arm_level_limit;
  assign lvl_above_adv = level > advance_level_limit;
  // point count clamped to the trace capacity
  assign last_pts = (point_count == '0) ? IDX_W'(0) :
                    (point_count > IDX_W'(MAX_POINTS)) ?
                    IDX_W'(MAX_POINTS - 1) : point_count - 1'b1;
  // end of pass: high limit, last list entry or last point
  assign at_end = (pidx_r >= last_pts) ||
                  (auto_hop_mode ? (addr_r >= list_last_entry) :
                   (lin_freq_r + freq_increment > sweep_high_freq));
  assign list_addr = addr_r;
  // a zero dwell would mark full at once and step every other cycle, so fall back to the default
  assign tif.dwell_cycles = (dwell_cycles == '0) ?
                            DWELL_W'(DWELL_DEF) : dwell_cycles;

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (start_stop) state_nxt = leader ? ST_DWELL : ST_ARM;
      ST_ARM: if (timed && lvl_above_arm) state_nxt = ST_WAITLO;
        else if (lvlf) state_nxt = ST_DWELL;
      ST_WAITLO: if (!lvl_above_arm) state_nxt = ST_STEP;
      ST_DWELL: begin
        if (leader && tif.full) state_nxt = ST_STEP;
        else if (timed && tif.full) state_nxt = ST_STEP;
        else if (lvlf && tif.full && !lvl_above_adv)
          state_nxt = ST_STEP;
      end
      ST_STEP: state_nxt = ST_DWELL;
      default: state_nxt = ST_IDLE;
    endcase
    if (state_r == ST_STEP && at_end) begin
      if (timed) state_nxt = ST_ARM;
      else if (leader && !repeat_pass) state_nxt = ST_IDLE;
      else state_nxt = ST_DWELL;
    end
    if (state_r != ST_IDLE && start_stop) state_nxt = ST_IDLE;
  end

  assign do_step = state_r == ST_STEP && state_nxt == ST_DWELL && !at_end;
  assign do_wrap = state_r == ST_STEP && at_end;
  assign tif.restart = state_r != ST_DWELL;
  // measure: arm edge (timed), 2/3 dwell once above threshold (level), dwell end (leader, timed)
  assign meas_now = (state_r == ST_ARM && timed && lvl_above_arm) ||
                    (state_r == ST_DWELL && lvlf && lvl_above_adv &&
                     tif.two_thirds && !measured_r) ||
                    (state_r == ST_DWELL && !lvlf && tif.full &&
                     !measured_r);

  // state, frequency and point registers; a new pass starts at low limit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      lin_freq_r <= '0;
      addr_r <= '0;
      pidx_r <= '0;
      step_r <= 1'b0;
      meas_r <= 1'b0;
      measured_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      step_r <= do_step || do_wrap;
      meas_r <= meas_now;
      if (meas_now) measured_r <= 1'b1;
      // clear on idle too, so a stop right after a measure cannot leave
      // the first point of the next run unmeasured
      else if (state_r == ST_STEP || state_r == ST_IDLE) measured_r <= 1'b0;
      if (state_r == ST_IDLE || do_wrap) begin
        lin_freq_r <= sweep_low_freq;
        addr_r <= list_first_entry;
        pidx_r <= '0;
      end else if (do_step) begin
        lin_freq_r <= lin_freq_r + freq_increment;
        addr_r <= addr_r + 1'b1;
        pidx_r <= pidx_r + 1'b1;
      end
    end
  end

  // outputs from registers except list-sourced frequency
  assign tuned_freq = auto_hop_mode ? list_freq : lin_freq_r;
  assign step_strobe = step_r;
  assign measure_strobe = meas_r;
  assign point_idx = pidx_r;
  assign running = state_r != ST_IDLE;

  // point index never exceeds trace capacity
  pts_cap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pidx_r < IDX_W'(MAX_POINTS)) else $error("point index over cap");
  // a wrap always restarts the point index
  pts_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    do_wrap |=> pidx_r == '0) else $error("point index not restarted");
  // a second press while running always ends the sequence
  stop_press_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r != ST_IDLE && start_stop) |=> !running)
    else $error("second press did not stop");
  // the high limit ends a one-pass run and restarts a repeat run
  one_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_STEP && at_end && leader && !repeat_pass && !start_stop)
    |=> state_r == ST_IDLE) else $error("one pass did not end");
  repeat_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (do_wrap && leader && repeat_pass && !start_stop) |=>
    (running && pidx_r == '0)) else $error("repeat did not restart");
  // linear steps add one increment, list steps one address
  lin_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (do_step && !auto_hop_mode) |=>
    lin_freq_r == $past(lin_freq_r) + $past(freq_increment))
    else $error("linear step wrong size");
  list_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (do_step && auto_hop_mode) |=> addr_r == $past(addr_r) + 1'b1)
    else $error("list step skipped an entry");
  // list addresses never pass the programmed last entry
  list_range_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (running && auto_hop_mode && list_first_entry <= list_last_entry) |->
    addr_r <= list_last_entry) else $error("list address past last entry");
  // a wrap returns to the low limit and the first list entry
  wrap_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    do_wrap |=> (lin_freq_r == $past(sweep_low_freq) &&
    addr_r == $past(list_first_entry))) else $error("wrap missed low limit");
  // the timed follower parks at the low limit until armed
  arm_meas_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_ARM && timed && lvl_above_arm) |=> measure_strobe)
    else $error("arm measure missing");
  arm_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_ARM && timed && !lvl_above_arm && !start_stop) |=>
    (state_r == ST_ARM && lin_freq_r == $past(lin_freq_r)))
    else $error("timed follower left the arm state");
  // timed stepping starts on the falling level, then runs on the timer
  timed_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_WAITLO && !lvl_above_arm && !start_stop) |=>
    state_r == ST_STEP) else $error("timed step did not begin");
  timed_pace_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_DWELL && timed && tif.full && !start_stop) |=>
    state_r == ST_STEP) else $error("timed step not paced by dwell");
  timed_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (do_wrap && timed && !start_stop) |=> state_r == ST_ARM)
    else $error("timed follower did not re-arm");
  // level follower: one late measure, advance only after a full dwell
  meas_late_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (meas_now && lvlf) |-> tif.two_thirds)
    else $error("level measure too early");
  meas_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (measure_strobe && lvlf) |=> !measure_strobe)
    else $error("level point measured twice");
  lvl_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_DWELL && lvlf && !tif.full && !start_stop) |=>
    state_r == ST_DWELL) else $error("level follower left early");
  lvl_adv_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_DWELL && lvlf && tif.full && !lvl_above_adv &&
     !start_stop) |=> state_r == ST_STEP)
    else $error("level follower did not advance");
  // the leader steps once per dwell with a strobe
  lead_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (do_step && leader) |=> (step_strobe && state_r == ST_DWELL))
    else $error("leader step strobe missing");
  lead_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_r == ST_DWELL && leader && !tif.full && !start_stop) |=>
    state_r == ST_DWELL) else $error("leader stepped before dwell");
endmodule // hop_sequencer

/* tb/sig_gen_model.sv */
// remote signal generator model giving a line level per step period
`timescale 1ns/1ps
module sig_gen_model #(
  parameter int PERIOD = 12,
  parameter int HIGH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control and line level
  input wire logic gen_on,
  output logic [hop_pkg::LEVEL_W-1:0] level
);
  int cnt;
  // step period at least the receiver dwell, same on both ends
  // stepped on the rising edge so the bench's falling-edge enable never races
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n || !gen_on) begin
      cnt <= 0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
  end
  // tone for HIGH cycles, then a gap while the generator retunes
  assign level = (gen_on && cnt < HIGH) ? 16'h4000 : 16'h0010;
endmodule // sig_gen_model

/* tb/hop_sequencer_bench.sv */
// self-checking bench for the auto frequency step sequencer
`timescale 1ns/1ps
module hop_sequencer_bench;
  import hop_pkg::*;
  localparam int DW = 8;
  localparam int DEF_DW = 20;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] role = ROLE_LEADER;
  logic auto_hop_mode = 1'b0;
  logic repeat_pass = 1'b0;
  logic [IDX_W-1:0] pts = 7'h0a;
  logic [IDX_W-1:0] first_e = 7'h02;
  logic [IDX_W-1:0] last_e = 7'h04;
  logic [DWELL_W-1:0] dwell = 24'(DW);
  logic [LEVEL_W-1:0] arm_lim = 16'h1000;
  logic [LEVEL_W-1:0] adv_lim = 16'h3000;
  logic start_stop = 1'b0;
  logic gen_on = 1'b0;
  logic [LEVEL_W-1:0] level;
  logic [IDX_W-1:0] list_addr, point_idx;
  logic [FREQ_W-1:0] tuned_freq, list_freq, nxt;
  logic [FREQ_W-1:0] exp_f = 32'h64;
  logic step_strobe, measure_strobe, running;
  int fails = 0, cmp_count = 0, steps = 0, meas = 0, run_cyc = 0, exp_pi = 0;
  always #5 mclk = ~mclk;
  // list entries read back as base plus address
  assign list_freq = 32'h1000 + {25'h0, list_addr};
  // generator period equals the receiver's: dwell plus one end-of-dwell cycle and one step cycle
  sig_gen_model #(.PERIOD(DW + 2), .HIGH(DW)) sig_gen_model_i (.mclk(mclk),
    .rst_n(rst_n), .gen_on(gen_on), .level(level));
  hop_sequencer #(.DWELL_DEF(DEF_DW)) hop_sequencer_i (.mclk(mclk),
    .rst_n(rst_n),
    .role(role), .auto_hop_mode(auto_hop_mode), .repeat_pass(repeat_pass),
    .sweep_low_freq(32'h64), .sweep_high_freq(32'h82),
    .freq_increment(32'ha), .list_first_entry(first_e),
    .list_last_entry(last_e), .point_count(pts), .dwell_cycles(dwell),
    .arm_level_limit(arm_lim), .advance_level_limit(adv_lim),
    .start_stop(start_stop), .level(level), .list_addr(list_addr),
    .list_freq(list_freq), .tuned_freq(tuned_freq),
    .step_strobe(step_strobe), .measure_strobe(measure_strobe),
    .point_idx(point_idx), .running(running));
  task automatic chk(input logic [FREQ_W-1:0] got, input logic [FREQ_W-1:0] e);
    cmp_count++;
    if (got !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  // every step must land on the next linear or list frequency, wrap incl.
  always @(negedge mclk) begin
    nxt = auto_hop_mode ? ((exp_f == 32'h1004) ? 32'h1002 : exp_f + 1)
                        : ((exp_f + 32'ha > 32'h82) ? 32'h64 : exp_f + 32'ha);
    if (running !== 1'b1) begin
      exp_f = auto_hop_mode ? 32'h1002 : 32'h64;
      exp_pi = 0;
    end else if (step_strobe === 1'b1) begin
      chk(tuned_freq, nxt);
      // the point index restarts with every wrap to the low limit
      exp_pi = (nxt == (auto_hop_mode ? 32'h1002 : 32'h64)) ? 0 : exp_pi + 1;
      chk({25'h0, point_idx}, exp_pi);
      exp_f = nxt;
      steps++;
    end
    if (running === 1'b1) run_cyc++;
    if (measure_strobe === 1'b1) meas++;
  end
  task automatic press();
    @(negedge mclk) start_stop = 1'b1;
    @(negedge mclk) start_stop = 1'b0;
  endtask
  task automatic leader(input int em, input int es);
    int d = (dwell == '0) ? DEF_DW : int'(dwell);
    @(posedge mclk) begin
      steps = 0;
      meas = 0;
      run_cyc = 0;
    end
    press();
    chk({31'h0, running}, 32'h1);
    for (int i = 0; i < 300 && running === 1'b1; i++) @(negedge mclk);
    chk({31'h0, running}, 32'h0);
    chk(meas, em);
    chk(steps, es);
    // each point runs the dwell plus one end-of-dwell cycle and one step cycle; zero picks the default
    chk(run_cyc, em * (d + 2));
    $display("leader test done, points %0d", em);
  endtask
  task automatic follower(input logic [1:0] r);
    role = r;
    gen_on = 1'b1;
    @(posedge mclk) begin
      steps = 0;
      meas = 0;
    end
    press();
    repeat (200) @(negedge mclk);
    chk({31'h0, running}, 32'h1);
    chk({31'h0, meas > 0 && steps > 0}, 32'h1);
    if (r == ROLE_LEVEL) chk({31'h0, meas >= steps && meas <= steps + 1},
                             32'h1);
    press();
    chk({31'h0, running}, 32'h0);
    gen_on = 1'b0;
    $display("follower test done, role %0d", r);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    leader(4, 3);
    pts = 7'h02;
    dwell = '0;
    leader(2, 1);
    pts = 7'h0a;
    dwell = 24'(DW);
    auto_hop_mode = 1'b1;
    leader(3, 2);
    auto_hop_mode = 1'b0;
    repeat_pass = 1'b1;
    press();
    repeat (80) @(negedge mclk);
    chk({31'h0, running}, 32'h1);
    press();
    chk({31'h0, running}, 32'h0);
    $display("repeat test done");
    follower(ROLE_TIMED);
    follower(ROLE_LEVEL);
    give_verdict();
  end
  // cut a hang short well past the expected run length
  initial begin
    #100000;
    fails++;
    give_verdict();
  end
endmodule // hop_sequencer_bench
